// file: common/edb_regs.vh
// Address map, entry offsets and configuration field positions of the
// endpoint descriptor blocks. Definitions only.
`ifndef EDB_REGS_VH
`define EDB_REGS_VH
`define EDB_OUT1_BASE 16'hFF08
`define EDB_OUT2_BASE 16'hFF10
`define EDB_OUT3_BASE 16'hFF18
`define EDB_IN1_BASE 16'hFF48
`define EDB_IN2_BASE 16'hFF50
`define EDB_IN3_BASE 16'hFF58
`define EDB_BLOCK_BYTES 4'h8
`define BUF_SPACE_LO 16'hFD80
`define BUF_SPACE_HI 16'hFEEF
`define BUF_SPACE_BYTES 16'h0170
`define OFS_CONFIG 3'h0
`define OFS_X_BASE 3'h1
`define OFS_X_COUNT 3'h2
`define OFS_SPARE_A 3'h3
`define OFS_SPARE_B 3'h4
`define OFS_Y_BASE 3'h5
`define OFS_Y_COUNT 3'h6
`define OFS_XY_SIZE 3'h7
`define CFG_IRQ_EN 2
`define CFG_STALL 3
`define CFG_DOUBLE_BUFFER_ENABLE 4
`define CFG_TOGGLE 5
`define CFG_ISO 6
`define CFG_BM_EN 7
`define CFG_WRITE_MASK 8'hFC
`define CNT_NAK 7
`define CNT_LEN_HI 6
`define BASE_PAD 3'h0
`define ANS_NONE 2'h0
`define ANS_ACK 2'h1
`define ANS_NAK 2'h2
`define ANS_STALL 2'h3
`endif

// file: logic/edb_decode.v
// Address decoder for the descriptor block window.
// Assumes a 16-bit data-space address from the microcontroller.
`timescale 1ns/1ns
`include "edb_regs.vh"
module edb_decode
(
  input wire [15:0] addr_i,
  output reg hit_o,
  output reg [2:0] slot_o,
  output reg [2:0] entry_o
);
  always @*
  begin
    hit_o = 1'b1;
    slot_o = 3'h0;
    entry_o = addr_i[2:0];
    case ({addr_i[15:3], 3'h0})
      `EDB_OUT1_BASE: slot_o = 3'h0;
      `EDB_OUT2_BASE: slot_o = 3'h1;
      `EDB_OUT3_BASE: slot_o = 3'h2;
      `EDB_IN1_BASE: slot_o = 3'h3;
      `EDB_IN2_BASE: slot_o = 3'h4;
      `EDB_IN3_BASE: slot_o = 3'h5;
      default: hit_o = 1'b0;
    endcase
  end
endmodule // edb_decode

// file: logic/usb_endpoint_descriptor_block.v
// Descriptor RAM for endpoints 1 to 3 in both directions, plus the buffer
// manager view of it: answer choice, buffer choice and toggle update.
// Assumes a byte-wide synchronous data-space port and a serial engine that
// presents one transaction request at a time and holds it for one cycle.
//
// How it works
// - Three in, three out descriptor blocks exist.
// - Endpoints 1-3 in RAM; endpoint 0 elsewhere.
// - Out blocks at FF08, FF10, FF18.
// - In blocks at FF48, FF50, FF58.
// - Data buffers span FD80 to FEEF.
// - X base at 01, X count 02.
// - Y base 05, Y count 06, 03/04 unused.
// - Config at 00, size at 07.
// - Bit 2 enables completion interrupt.
// - Bit 3 stalls; firmware clears; resets zero.
// - Bit 4 enables toggle-selected X/Y buffers.
// - Bit 5 holds the data toggle.
// - Bit 7 lets buffer manager service endpoint.
// - Base entry padded with three zeros, unchanged.
// - Count top bit set means NAK further on out; in blocks NAK while it is clear.
`timescale 1ns/1ns
`include "edb_regs.vh"
module usb_endpoint_descriptor_block
(
  input wire clk_sys_i,
  input wire srst_i,
  input wire [15:0] mcu_addr_i,
  input wire mcu_wr_i,
  input wire mcu_rd_i,
  input wire [7:0] mcu_wdata_i,
  output reg [7:0] mcu_rdata_o,
  output reg mcu_hit_o,
  input wire txn_req_i,
  input wire txn_in_i,
  input wire [1:0] txn_ep_i,
  input wire txn_toggle_i,
  input wire [6:0] txn_len_i,
  output reg [1:0] txn_answer_o,
  output reg [10:0] txn_buf_addr_o,
  output reg txn_buf_y_o,
  output reg [6:0] txn_count_o,
  input wire txn_done_i,
  output reg completion_irq_o,
  output reg [2:0] irq_slot_o
);
  // Six blocks of eight bytes; spare bytes are stored so software can use them.
  reg [7:0] edb_ram [0:47];
  reg [7:0] stall_bits;
  wire dec_hit;
  wire [2:0] dec_slot;
  wire [2:0] dec_entry;
  reg [2:0] act_slot;
  reg act_busy;
  reg act_y;
  reg [1:0] next_answer;
  reg [7:0] cfg_now;
  reg [7:0] cnt_now;
  reg [7:0] base_now;
  reg use_y;
  reg [2:0] req_slot;
  integer i;

  function [5:0] ram_index;
    input [2:0] slot;
    input [2:0] entry;
    begin
      ram_index = {slot, entry};
    end
  endfunction

  function buf_in_space;
    input [10:0] start;
    reg [15:0] full;
    begin
      full = {5'h1F, start};
      buf_in_space = (full >= `BUF_SPACE_LO) && (full <= `BUF_SPACE_HI);
    end
  endfunction

  edb_decode u_decode
  (
    .addr_i(mcu_addr_i),
    .hit_o(dec_hit),
    .slot_o(dec_slot),
    .entry_o(dec_entry)
  );

  always @*
  begin
    req_slot = txn_in_i ? {1'b0, txn_ep_i} + 3'h2 : {1'b0, txn_ep_i} - 3'h1;
    cfg_now = edb_ram[ram_index(req_slot, `OFS_CONFIG)];
    // Without double buffering only X is used; with it the toggle picks.
    use_y = cfg_now[`CFG_DOUBLE_BUFFER_ENABLE] & cfg_now[`CFG_TOGGLE];
    cnt_now = use_y ? edb_ram[ram_index(req_slot, `OFS_Y_COUNT)]
                    : edb_ram[ram_index(req_slot, `OFS_X_COUNT)];
    base_now = use_y ? edb_ram[ram_index(req_slot, `OFS_Y_BASE)]
                     : edb_ram[ram_index(req_slot, `OFS_X_BASE)];
    if (stall_bits[req_slot])
      next_answer = `ANS_STALL;
    else if (!cfg_now[`CFG_BM_EN])
      next_answer = `ANS_NAK;
    else if (!txn_in_i && cnt_now[`CNT_NAK])
      next_answer = `ANS_NAK;
    else if (txn_in_i && !cnt_now[`CNT_NAK])
      next_answer = `ANS_NAK;
    else if (!buf_in_space({base_now, `BASE_PAD}))
      next_answer = `ANS_NAK;
    else
      next_answer = `ANS_ACK;
  end

  always @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      mcu_rdata_o <= 8'h00;
      mcu_hit_o <= 1'b0;
      txn_answer_o <= `ANS_NONE;
      txn_buf_addr_o <= 11'h000;
      txn_buf_y_o <= 1'b0;
      txn_count_o <= 7'h00;
      completion_irq_o <= 1'b0;
      irq_slot_o <= 3'h0;
      stall_bits <= 8'h00;
      act_slot <= 3'h0;
      act_busy <= 1'b0;
      act_y <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
        edb_ram[ram_index(i[2:0], `OFS_CONFIG)] <= 8'h00;
    end
    else
    begin
      completion_irq_o <= 1'b0;
      txn_answer_o <= `ANS_NONE;
      mcu_hit_o <= dec_hit & (mcu_rd_i | mcu_wr_i);
      if (mcu_rd_i && dec_hit)
      begin
        if (dec_entry == `OFS_CONFIG)
          mcu_rdata_o <= (edb_ram[ram_index(dec_slot, dec_entry)] & `CFG_WRITE_MASK) |
                         {4'h0, stall_bits[dec_slot], 3'h0};
        else
          mcu_rdata_o <= edb_ram[ram_index(dec_slot, dec_entry)];
      end
      else if (mcu_rd_i)
        mcu_rdata_o <= 8'h00;
      if (mcu_wr_i && dec_hit)
      begin
        if (dec_entry == `OFS_CONFIG)
        begin
          // Bit 6 is stored as written; keeping it clear is software's job.
          edb_ram[ram_index(dec_slot, dec_entry)] <= mcu_wdata_i & `CFG_WRITE_MASK;
          stall_bits[dec_slot] <= mcu_wdata_i[`CFG_STALL];
        end
        else
          edb_ram[ram_index(dec_slot, dec_entry)] <= mcu_wdata_i;
      end
      if (txn_req_i && !act_busy)
      begin
        txn_answer_o <= next_answer;
        txn_buf_addr_o <= {base_now, `BASE_PAD};
        txn_buf_y_o <= use_y;
        txn_count_o <= cnt_now[`CNT_LEN_HI:0];
        if (next_answer == `ANS_ACK)
        begin
          act_busy <= 1'b1;
          act_slot <= req_slot;
          act_y <= use_y;
        end
      end
      else if (txn_done_i && act_busy)
      begin
        // Completion flips the toggle and marks the buffer; base stays.
        act_busy <= 1'b0;
        edb_ram[ram_index(act_slot, `OFS_CONFIG)] <=
          edb_ram[ram_index(act_slot, `OFS_CONFIG)] ^ (8'h01 << `CFG_TOGGLE);
        if (act_y)
          edb_ram[ram_index(act_slot, `OFS_Y_COUNT)] <= act_slot < 3'h3 ?
            {1'b1, txn_len_i} : 8'h80;
        else
          edb_ram[ram_index(act_slot, `OFS_X_COUNT)] <= act_slot < 3'h3 ?
            {1'b1, txn_len_i} : 8'h80;
        completion_irq_o <= edb_ram[ram_index(act_slot, `OFS_CONFIG)][`CFG_IRQ_EN];
        irq_slot_o <= act_slot;
      end
    end
  end
endmodule // usb_endpoint_descriptor_block

// file: tb/edb_engine_model.sv
// Serial engine stand-in: turns a go strobe into one request, confirms every ACK.
// Assumes the descriptor block answers on the cycle after the request.
`timescale 1ns/1ns
`include "edb_regs.vh"
module edb_engine_model
(
  input wire clk_sys_i,
  input wire go_i,
  input wire [1:0] ep_i,
  input wire [1:0] ans_i,
  output reg req_o,
  output reg [1:0] ep_o,
  output reg done_o
);
  initial
  begin
    req_o = 1'b0;
    ep_o = 2'h0;
    done_o = 1'b0;
  end
  // Completion follows only an ACK, so a refused request never looks finished.
  always @(posedge clk_sys_i)
  begin
    req_o <= go_i;
    ep_o <= ep_i;
    done_o <= (ans_i == `ANS_ACK);
  end
endmodule // edb_engine_model

// file: tb/edb_checker_properties.sv
// Timing relations at the descriptor block's ports.
// Assumes the register map and answer codes of the shared header.
`timescale 1ns/1ns
`include "edb_regs.vh"
module edb_checker
(
  input wire clk_sys_i,
  input wire srst_i,
  input wire [15:0] mcu_addr_i,
  input wire mcu_wr_i,
  input wire mcu_rd_i,
  input wire [7:0] mcu_rdata_o,
  input wire mcu_hit_o,
  input wire txn_done_i,
  input wire [1:0] txn_answer_o,
  input wire [10:0] txn_buf_addr_o,
  input wire completion_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_gap; mcu_rd_i && mcu_addr_i == 16'hFF20 |=> !mcu_hit_o && mcu_rdata_o == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("unmapped read answered");
  property p_in3; mcu_rd_i && mcu_addr_i == 16'hFF58 |=> mcu_hit_o; endproperty
  a_in3: assert property (p_in3) else $error("in block not hit");
  property p_hit; mcu_hit_o |-> $past(mcu_rd_i || mcu_wr_i); endproperty
  a_hit: assert property (p_hit) else $error("hit without access");
  property p_rsv; mcu_rd_i && mcu_addr_i == 16'hFF08 |=> mcu_rdata_o[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_stall; txn_answer_o == `ANS_STALL |=> txn_answer_o == `ANS_NONE; endproperty
  a_stall: assert property (p_stall) else $error("stall answer too long");
  property p_pad; txn_answer_o == `ANS_ACK |-> txn_buf_addr_o[2:0] == 3'h0; endproperty
  a_pad: assert property (p_pad) else $error("start address not padded");
  property p_span; txn_answer_o == `ANS_ACK |-> txn_buf_addr_o inside {[11'h580:11'h6E8]};
  endproperty
  a_span: assert property (p_span) else $error("buffer outside data space");
  property p_irq; completion_irq_o |-> $past(txn_done_i); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without completion");
endmodule // edb_checker
bind usb_endpoint_descriptor_block edb_checker chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .mcu_addr_i(mcu_addr_i), .mcu_wr_i(mcu_wr_i), .mcu_rd_i(mcu_rd_i), .mcu_rdata_o(mcu_rdata_o),
  .mcu_hit_o(mcu_hit_o), .txn_done_i(txn_done_i), .txn_answer_o(txn_answer_o),
  .txn_buf_addr_o(txn_buf_addr_o), .completion_irq_o(completion_irq_o));

// file: tb/tb.sv
// Self-checking bench for the descriptor block with the engine stand-in.
// Assumes one 250 MHz clock and the shared header on the include path.
`timescale 1ns/1ns
`include "edb_regs.vh"
module tb;
  logic clk_sys_i = 0, srst_i = 1, rd = 0, wr = 0, go = 0, req, done, irq, irq_seen = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] ep = 2'h1, ans;
  logic tin = 1'b0;
  logic [10:0] badr;
  logic [1:0] mep;
  logic [6:0] cnt;
  logic [2:0] slot;
  logic hit, by;
  int failures = 0, checked = 0;
  logic [31:0] rows [0:6] = '{32'hFF08BFBC, 32'hFF09B0B0, 32'hFF0A0000, 32'hFF0DC1C1,
    32'hFF0E3333, 32'hFF175A5A, 32'hFF588484};
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (irq === 1'b1) irq_seen <= 1'b1;
  usb_endpoint_descriptor_block dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .mcu_addr_i(addr), .mcu_wr_i(wr), .mcu_rd_i(rd), .mcu_wdata_i(wdata), .mcu_rdata_o(rdata),
    .mcu_hit_o(hit), .txn_req_i(req), .txn_in_i(tin), .txn_ep_i(mep), .txn_toggle_i(1'b0),
    .txn_len_i(7'h05), .txn_answer_o(ans), .txn_buf_addr_o(badr), .txn_buf_y_o(by),
    .txn_count_o(cnt), .txn_done_i(done), .completion_irq_o(irq), .irq_slot_o(slot));
  edb_engine_model eng_u (.clk_sys_i(clk_sys_i), .go_i(go), .ep_i(ep), .ans_i(ans),
    .req_o(req), .ep_o(mep), .done_o(done));
  task cmp(input [15:0] got, input [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_b(input [15:0] a, input [7:0] d);
    @(posedge clk_sys_i) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge clk_sys_i) wr <= 0;
  endtask
  task rd_b(input [15:0] a);
    @(posedge clk_sys_i) begin addr <= a; rd <= 1; end
    @(posedge clk_sys_i) rd <= 0;
    #1;
  endtask
  // The answer is looked at in its single cycle; the wait is bounded.
  task txn(input [1:0] exp);
    @(posedge clk_sys_i) go <= 1;
    @(posedge clk_sys_i) go <= 0;
    repeat (4) @(posedge clk_sys_i) #1 if (ans !== `ANS_NONE) break;
    cmp(ans, exp);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    failures++;
    stop_test;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 0;
    foreach (rows[i])
    begin
      wr_b(rows[i][31:16], rows[i][15:8]);
      rd_b(rows[i][31:16]);
      cmp(rdata, rows[i][7:0]);
    end
    $display("table done");
    wr_b(16'hFF08, 8'h88);
    txn(`ANS_STALL);
    wr_b(16'hFF08, 8'h04);
    txn(`ANS_NAK);
    wr_b(16'hFF08, 8'h84);
    txn(`ANS_ACK);
    cmp(badr, 11'h580);
    cmp(by, 1'b0);
    cmp(irq_seen, 1'b1);
    cmp(slot, 3'h0);
    cmp(cnt, 7'h00);
    rd_b(16'hFF0A);
    cmp(rdata, 8'h85);
    rd_b(16'hFF08);
    cmp(rdata, 8'hA4);
    txn(`ANS_NAK);
    wr_b(16'hFF20, 8'h77);
    rd_b(16'hFF20);
    cmp(rdata, 8'h00);
    $display("transactions done");
    // Input endpoint 3: the buffer must be loaded before the host may take it.
    wr_b(16'hFF59, 8'hB1);
    wr_b(16'hFF5A, 8'h83);
    @(posedge clk_sys_i)
    begin
      ep <= 2'h3;
      tin <= 1'b1;
    end
    txn(`ANS_ACK);
    cmp(badr, 11'h588);
    cmp(cnt, 7'h03);
    cmp(slot, 3'h5);
    rd_b(16'hFF58);
    cmp(rdata, 8'hA4);
    rd_b(16'hFF59);
    cmp(rdata, 8'hB1);
    $display("in endpoint done");
    @(posedge clk_sys_i) srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd_b(16'hFF58);
    cmp(rdata, 8'h00);
    $display("reset done");
    stop_test;
  end
endmodule // tb
